// ===== inc/adcsq_pkg.sv
// Constants shared by the ADC sequencer control block
package adcsq_pkg;

  // Register bus widths and offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h5f;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASKS = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CONTROL = 8'h61;
  localparam logic [ADDR_W-1:0] OFS_GAIN_LOW = 8'h62;

  // Reset values
  localparam logic [DATA_W-1:0] RST_REG = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // Event flag and mask bit positions
  localparam int FLAG_N = 3;
  localparam int BIT_CYCLE_DONE = 0;
  localparam int BIT_PEN_CONTACT = 1;
  localparam int BIT_HALF_SCALE = 2;

  // Sequencer control fields
  localparam int SLEEP_LSB = 0;
  localparam int SLEEP_W = 3;
  localparam int BIT_CC_ENABLE = 3;
  localparam int BIT_CC_CLEAR = 4;
  localparam int BIT_PEN_BIAS = 5;
  localparam int BIT_SEQ_RUN = 6;
  localparam int BIT_POWER_ON = 7;
  localparam logic [SLEEP_W-1:0] SLEEP_CONTINUOUS = 3'h0;
  localparam logic [SLEEP_W-1:0] SLEEP_ONE_SHOT = 3'h7;

  // Gain select layout: channels 10..16, the first four shared with touch
  localparam int GAIN_N = 7;
  localparam int GAIN_TOUCH_N = 4;

  // Coulomb counter bit that marks half of full scale
  localparam int CC_W = 16;
  localparam int CC_HALF_BIT = 14;

  // Sleep timing: each code step is 4.5 ms
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SLEEP_STEP_US = 4500;
  localparam int unsigned SLEEP_STEP_CYC = SLEEP_STEP_US * CLK_MHZ;
  localparam int TICK_W = 20;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_SLEEP = 3'b100
  } adcsq_state_e;

endpackage

// ===== logic/adcsq_sleep_timer.sv
// Sleep interval timer between round-robin cycles
`timescale 1ns/1ps
module adcsq_sleep_timer
  import adcsq_pkg::*;
#(
  parameter int unsigned STEP_CYC = SLEEP_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [SLEEP_W-1:0] code,
  output logic done
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STEP_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = '0;
  localparam logic [SLEEP_W-1:0] REP_ONE = 3'h1;
  localparam logic [SLEEP_W-1:0] REP_ZERO = 3'h0;

  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic [SLEEP_W-1:0] rep_r, rep_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  // Count code steps of one sleep step each
  always_comb begin
    tick_nxt = tick_r;
    rep_nxt = rep_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (abort) begin
      busy_nxt = 1'b0;
    end else if (start) begin
      busy_nxt = 1'b1;
      tick_nxt = TICK_LAST;
      rep_nxt = code;
    end else if (busy_r) begin
      if (tick_r != TICK_ZERO) begin
        tick_nxt = tick_r - 1'b1;
      end else if (rep_r <= REP_ONE) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        rep_nxt = REP_ZERO;
      end else begin
        rep_nxt = rep_r - 1'b1;
        tick_nxt = TICK_LAST;
      end
    end
  end

  // Timer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_r <= TICK_ZERO;
      rep_r <= REP_ZERO;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      rep_r <= rep_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;

endmodule

// ===== logic/adcsq_control.sv
// ADC sequencer event flags, masks, control and gain registers
//
// Operation
// R1 - Completed round-robin cycle sets cycle-done flag
// R2 - Pen contact sets pen-contact flag
// R3 - Half-scale coulomb count sets half-scale flag
// R4 - Mask bits 0..2; one blocks event
// R5 - Unmasked half-scale flag raises host interrupt
// R6 - Half-scale event on count bit 14 rising
// R7 - Sleep field: loop, 4.5ms steps, one-shot
// R8 - Control bit 3 enables coulomb counting
// R9 - Writing bit 4 clears coulomb counter
// R10 - Clear bit drops back by itself
// R11 - Control bit 5 enables pen bias
// R12 - Bit 6 starts; zero stops after cycle
// R13 - Bit 7 forces converter full power
// R14 - Gain bits select x1 or x10, ch10-16
// R15 - Ch10-13 gain ignored while pen biased
// R16 - All registers reset zero; flags read-only
// R17 - Flags stay until read, read clears them
`timescale 1ns/1ps
module adcsq_control
  import adcsq_pkg::*;
#(
  parameter int unsigned STEP_CYC = SLEEP_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pen_contact_pin,
  input wire logic cycle_end,
  input wire logic [CC_W-1:0] charge_count_value,
  output logic host_irq_out,
  output logic cycle_start,
  output logic seq_busy,
  output logic converter_full_power,
  output logic charge_count_enable,
  output logic charge_count_clear,
  output logic pen_bias_enable,
  output logic [GAIN_N-1:0] gain_x10
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic pen_s1_r, pen_s2_r, pen_s3_r;
  logic pen_s1_nxt, pen_s2_nxt, pen_s3_nxt;
  logic half_prev_r, half_prev_nxt;
  logic [FLAG_N-1:0] flags_r, flags_nxt;
  logic [FLAG_N-1:0] masks_r, masks_nxt;
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [GAIN_N-1:0] gain_r, gain_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic irq_r, irq_nxt;
  logic start_r, start_nxt;
  logic busy_r, busy_nxt;
  logic power_r, power_nxt;
  logic cc_en_r, cc_en_nxt;
  logic cc_clr_r, cc_clr_nxt;
  logic bias_r, bias_nxt;
  logic [GAIN_N-1:0] gain_out_r;
  logic [GAIN_N-1:0] gain_eff;
  adcsq_state_e state_r, state_nxt;

  logic [FLAG_N-1:0] events;
  logic wr_flags, wr_masks, wr_ctrl, wr_gain;
  logic rd_flags;
  logic tmr_start, tmr_abort, tmr_done;
  logic [SLEEP_W-1:0] sleep_code;
  logic run_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Pen contact pin synchroniser and edge stage

  // Two sync stages, then one stage to find the rising edge
  always_comb begin
    pen_s1_nxt = pen_contact_pin;
    pen_s2_nxt = pen_s1_r;
    pen_s3_nxt = pen_s2_r;
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pen_s1_r <= 1'b0;
      pen_s2_r <= 1'b0;
      pen_s3_r <= 1'b0;
    end else begin
      pen_s1_r <= pen_s1_nxt;
      pen_s2_r <= pen_s2_nxt;
      pen_s3_r <= pen_s3_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode and event sources

  assign wr_flags = reg_wr && (reg_addr == OFS_EVENT_FLAGS);
  assign wr_masks = reg_wr && (reg_addr == OFS_EVENT_MASKS);
  assign wr_ctrl = reg_wr && (reg_addr == OFS_SEQ_CONTROL);
  assign wr_gain = reg_wr && (reg_addr == OFS_GAIN_LOW);
  assign rd_flags = reg_rd && (reg_addr == OFS_EVENT_FLAGS);
  assign sleep_code = ctrl_r[SLEEP_LSB +: SLEEP_W];
  assign run_bit = ctrl_r[BIT_SEQ_RUN];

  // Event pulses
  always_comb begin
    events = '0;
    events[BIT_CYCLE_DONE] = cycle_end && (state_r == ST_CONV); // R1
    events[BIT_PEN_CONTACT] = pen_s2_r && !pen_s3_r; // R2
    events[BIT_HALF_SCALE] = charge_count_value[CC_HALF_BIT] &&
                             !half_prev_r; // R3 R6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective gain: touch channels fall back to unity while biased
  // Built from next values so gain moves on the edge that bias does

  genvar gi;
  generate
    for (gi = 0; gi < GAIN_N; gi++) begin : g_gain
      if (gi < GAIN_TOUCH_N) begin : g_touch
        assign gain_eff[gi] = gain_nxt[gi] && !ctrl_nxt[BIT_PEN_BIAS]; // R15
      end else begin : g_plain
        assign gain_eff[gi] = gain_nxt[gi]; // R14
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file, sequencer and output next values

  always_comb begin
    flags_nxt = flags_r;
    masks_nxt = masks_r;
    ctrl_nxt = ctrl_r;
    gain_nxt = gain_r;
    state_nxt = state_r;
    half_prev_nxt = charge_count_value[CC_HALF_BIT];
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    start_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    cc_clr_nxt = 1'b0;

    // Read returns flags and clears them; new events win
    if (rd_flags) begin
      flags_nxt = '0; // R17
    end
    flags_nxt = flags_nxt | events; // R1 R2 R3 R17

    // Flag register ignores writes
    if (wr_flags) begin
      flags_nxt = flags_nxt; // R16
    end

    // Sequencer
    unique case (state_r)
      ST_IDLE: begin
        if (run_bit) begin
          state_nxt = ST_CONV; // R12
          start_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        if (cycle_end) begin
          if (sleep_code == SLEEP_ONE_SHOT) begin
            ctrl_nxt[BIT_SEQ_RUN] = 1'b0; // R7
            state_nxt = ST_IDLE;
          end else if (!run_bit) begin
            state_nxt = ST_IDLE; // R12
          end else if (sleep_code == SLEEP_CONTINUOUS) begin
            start_nxt = 1'b1; // R7
          end else begin
            state_nxt = ST_SLEEP; // R7
            tmr_start = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (!run_bit) begin
          state_nxt = ST_IDLE; // R12
          tmr_abort = 1'b1;
        end else if (tmr_done) begin
          state_nxt = ST_CONV; // R7
          start_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase

    // Software writes take precedence over hardware run clear
    if (wr_masks) begin
      masks_nxt = reg_wdata[FLAG_N-1:0]; // R4
    end
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata;
      ctrl_nxt[BIT_CC_CLEAR] = 1'b0; // R10
      cc_clr_nxt = reg_wdata[BIT_CC_CLEAR]; // R9
    end
    if (wr_gain) begin
      gain_nxt = reg_wdata[GAIN_N-1:0]; // R14
    end

    // Read data, unmapped offsets read zero
    if (reg_rd) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = READ_ZERO;
      if (reg_addr == OFS_EVENT_FLAGS) begin
        rdata_nxt[FLAG_N-1:0] = flags_r;
      end else if (reg_addr == OFS_EVENT_MASKS) begin
        rdata_nxt[FLAG_N-1:0] = masks_r;
      end else if (reg_addr == OFS_SEQ_CONTROL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == OFS_GAIN_LOW) begin
        rdata_nxt[GAIN_N-1:0] = gain_r;
      end
    end

    // Interrupt and control outputs
    irq_nxt = |(flags_nxt & ~masks_nxt); // R4 R5
    busy_nxt = (state_nxt != ST_IDLE);
    power_nxt = ctrl_nxt[BIT_POWER_ON]; // R13
    cc_en_nxt = ctrl_nxt[BIT_CC_ENABLE]; // R8
    bias_nxt = ctrl_nxt[BIT_PEN_BIAS]; // R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= '0; // R16
      masks_r <= '0;
      ctrl_r <= RST_REG;
      gain_r <= '0;
      state_r <= ST_IDLE;
      half_prev_r <= 1'b0;
      rdata_r <= READ_ZERO;
      rvalid_r <= 1'b0;
      irq_r <= 1'b0;
      start_r <= 1'b0;
      busy_r <= 1'b0;
      power_r <= 1'b0;
      cc_en_r <= 1'b0;
      cc_clr_r <= 1'b0;
      bias_r <= 1'b0;
      gain_out_r <= '0;
    end else begin
      flags_r <= flags_nxt;
      masks_r <= masks_nxt;
      ctrl_r <= ctrl_nxt;
      gain_r <= gain_nxt;
      state_r <= state_nxt;
      half_prev_r <= half_prev_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      irq_r <= irq_nxt;
      start_r <= start_nxt;
      busy_r <= busy_nxt;
      power_r <= power_nxt;
      cc_en_r <= cc_en_nxt;
      cc_clr_r <= cc_clr_nxt;
      bias_r <= bias_nxt;
      gain_out_r <= gain_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep interval timer

  adcsq_sleep_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_sleep (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .abort(tmr_abort),
    .code(sleep_code),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign host_irq_out = irq_r;
  assign cycle_start = start_r;
  assign seq_busy = busy_r;
  assign converter_full_power = power_r;
  assign charge_count_enable = cc_en_r;
  assign charge_count_clear = cc_clr_r;
  assign pen_bias_enable = bias_r;
  assign gain_x10 = gain_out_r;

endmodule

// ===== bench/adcsq_control_sva.sv
// Assertion checker for the ADC sequencer control block
`timescale 1ns/1ps
module adcsq_control_sva
  import adcsq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic host_irq_out,
  input wire logic cycle_start,
  input wire logic seq_busy,
  input wire logic converter_full_power,
  input wire logic charge_count_enable,
  input wire logic charge_count_clear,
  input wire logic pen_bias_enable,
  input wire logic [GAIN_N-1:0] gain_x10
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wctl;
  ////////////////////////////////////////////////////////////////////////////
  // Control write decode
  assign wctl = reg_wr && reg_addr == OFS_SEQ_CONTROL;
  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_cc_en;
    wctl |=> charge_count_enable == $past(reg_wdata[BIT_CC_ENABLE]);
  endproperty
  a_cc_en: assert property (p_cc_en) else $error("cc enable");
  property p_clr_set;
    wctl && reg_wdata[BIT_CC_CLEAR] |=> charge_count_clear;
  endproperty
  a_clr_set: assert property (p_clr_set) else $error("no clear");
  property p_clr_once;
    charge_count_clear |-> $past(wctl) && $past(reg_wdata[BIT_CC_CLEAR]);
  endproperty
  a_clr_once: assert property (p_clr_once) else $error("clear");
  property p_bias;
    wctl |=> pen_bias_enable == $past(reg_wdata[BIT_PEN_BIAS]);
  endproperty
  a_bias: assert property (p_bias) else $error("bias");
  property p_power;
    wctl |=> converter_full_power == $past(reg_wdata[BIT_POWER_ON]);
  endproperty
  a_power: assert property (p_power) else $error("power");
  property p_gain;
    pen_bias_enable |-> gain_x10[GAIN_TOUCH_N-1:0] == 4'h0;
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_gain_wr;
    reg_wr && reg_addr == OFS_GAIN_LOW && !pen_bias_enable
      |=> gain_x10 == $past(reg_wdata[GAIN_N-1:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) else $error("gain write");
  property p_start;
    wctl && reg_wdata[BIT_SEQ_RUN] && !seq_busy |=> ##1 cycle_start;
  endproperty
  a_start: assert property (p_start) else $error("start");
  property p_mask;
    reg_wr && reg_addr == OFS_EVENT_MASKS && reg_wdata[2:0] == 3'h7
      |=> !host_irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_flag_rd;
    reg_rd && reg_addr == OFS_EVENT_FLAGS
      |=> reg_rvalid && reg_rdata[7:3] == 5'h00;
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flags");
  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios seen
  c_run: cover property (cycle_start);
  c_irq: cover property ($rose(host_irq_out));
  c_clr: cover property (charge_count_clear);
  c_stop: cover property ($fell(seq_busy));
endmodule

// ===== bench/adcsq_control_tb.sv
// Self-checking bench for the ADC sequencer control block
`timescale 1ns/1ps
module adcsq_control_tb
  import adcsq_pkg::*;
;
  localparam int STEP = 20;
  logic clk, rst = 1, reg_wr = 0, reg_rd = 0, pen_contact_pin = 0;
  logic cycle_end = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] charge_count_value = 16'h0000;
  logic [7:0] reg_rdata;
  logic [6:0] gain_x10;
  logic reg_rvalid, host_irq_out, cycle_start, seq_busy;
  logic converter_full_power, charge_count_enable, charge_count_clear;
  logic pen_bias_enable;
  int n_mismatch = 0, checks = 0;
  adcsq_control #(.STEP_CYC(STEP)) dut (.clk, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .pen_contact_pin,
    .cycle_end, .charge_count_value, .host_irq_out, .cycle_start,
    .seq_busy, .converter_full_power, .charge_count_enable,
    .charge_count_clear, .pen_bias_enable, .gain_x10);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    chk("rvalid", 8'(reg_rvalid), 8'h01);
    chk("rdata", reg_rdata, e);
  endtask
  task end_cycle;
    @(negedge clk);
    cycle_end = 1;
    @(negedge clk);
    cycle_end = 0;
  endtask
  task wait_start(output int n);
    n = 0;
    while (cycle_start !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) chk("start", 8'h00, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    chk("outs", 8'({cycle_start, seq_busy, charge_count_clear,
      host_irq_out, gain_x10 !== 7'h00}), 8'h00);
    for (int a = 'h5e; a <= 'h63; a++) rd(8'(a), 8'h00);
    wr(OFS_EVENT_FLAGS, 8'hff);
    rd(OFS_EVENT_FLAGS, 8'h00);
    wr(OFS_EVENT_MASKS, 8'hff);
    rd(OFS_EVENT_MASKS, 8'h07);
  endtask
  task t_ctrl;
    wr(OFS_SEQ_CONTROL, 8'hb8);
    chk("ctl", 8'({converter_full_power, pen_bias_enable,
      charge_count_clear, charge_count_enable}), 8'h0f);
    @(negedge clk);
    chk("clr", 8'(charge_count_clear), 8'h00);
    rd(OFS_SEQ_CONTROL, 8'ha8);
    wr(OFS_GAIN_LOW, 8'h7f);
    chk("gain", 8'(gain_x10), 8'h70);
    rd(OFS_GAIN_LOW, 8'h7f);
    wr(OFS_SEQ_CONTROL, 8'h00);
    chk("gain", 8'(gain_x10), 8'h7f);
    wr(OFS_GAIN_LOW, 8'h15);
    chk("gain", 8'(gain_x10), 8'h15);
  endtask
  task t_events;
    wr(OFS_EVENT_MASKS, 8'h03);
    pen_contact_pin = 1;
    repeat (6) @(negedge clk);
    chk("irq", 8'(host_irq_out), 8'h00);
    charge_count_value = 16'h4000;
    repeat (3) @(negedge clk);
    chk("irq", 8'(host_irq_out), 8'h01);
    rd(OFS_EVENT_FLAGS, 8'h06);
    chk("irq", 8'(host_irq_out), 8'h00);
    rd(OFS_EVENT_FLAGS, 8'h00);
    pen_contact_pin = 0;
    wr(OFS_EVENT_MASKS, 8'h00);
  endtask
  task t_seq;
    int n;
    end_cycle;
    rd(OFS_EVENT_FLAGS, 8'h00);
    for (int c = 0; c < 7; c++) begin
      wr(OFS_SEQ_CONTROL, 8'h40 | 8'(c));
      wait_start(n);
      end_cycle;
      wait_start(n);
      chk("sleep", 8'(n >= c * STEP && n <= c * STEP + 5), 8'h01);
      wr(OFS_SEQ_CONTROL, 8'h00);
      chk("busy", 8'(seq_busy), 8'h01);
      end_cycle;
      @(negedge clk);
      chk("busy", 8'(seq_busy), 8'h00);
    end
    rd(OFS_EVENT_FLAGS, 8'h01);
  endtask
  task t_abort;
    int n;
    wr(OFS_SEQ_CONTROL, 8'h42);
    wait_start(n);
    end_cycle;
    wr(OFS_SEQ_CONTROL, 8'h00);
    @(negedge clk);
    chk("busy", 8'(seq_busy), 8'h00);
    n = 0;
    repeat (3 * STEP) begin
      @(negedge clk);
      if (cycle_start !== 1'b0) n++;
    end
    chk("start", 8'(n), 8'h00);
    rd(OFS_EVENT_FLAGS, 8'h01);
  endtask
  task t_one_shot;
    int n;
    wr(OFS_SEQ_CONTROL, 8'h47);
    wait_start(n);
    end_cycle;
    chk("irq", 8'(host_irq_out), 8'h01);
    repeat (3) @(negedge clk);
    chk("busy", 8'(seq_busy), 8'h00);
    rd(OFS_SEQ_CONTROL, 8'h07);
    rd(OFS_EVENT_FLAGS, 8'h01);
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    t_reset;
    t_ctrl;
    t_events;
    t_seq;
    t_abort;
    t_one_shot;
    tally_and_finish;
  end
endmodule
bind adcsq_control adcsq_control_sva u_sva (.clk, .rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .host_irq_out,
  .cycle_start, .seq_busy, .converter_full_power, .charge_count_enable,
  .charge_count_clear, .pen_bias_enable, .gain_x10);
